//--- hw/arm_pkg.sv
// Constants and types for the converter register map and status block
package arm_pkg;

  // Register addresses
  localparam logic [7:0] ADDR_STATUS   = 8'h00;
  localparam logic [7:0] ADDR_GLOBAL   = 8'h01;
  localparam logic [7:0] ADDR_OUTFMT   = 8'h02;
  localparam logic [7:0] ADDR_AVGRATIO = 8'h03;
  localparam logic [7:0] ADDR_OSCTIME  = 8'h04;
  localparam logic [7:0] ADDR_CHFUNC   = 8'h05;
  localparam logic [7:0] ADDR_DIGDIR   = 8'h07;
  localparam logic [7:0] ADDR_DRVTYPE  = 8'h09;
  localparam logic [7:0] ADDR_DOUTLVL  = 8'h0B;
  localparam logic [7:0] ADDR_DINLVL   = 8'h0D;
  localparam logic [7:0] ADDR_SCANCTL  = 8'h10;
  localparam logic [7:0] ADDR_MANCH    = 8'h11;
  localparam logic [7:0] ADDR_SCANEN   = 8'h12;

  // Serial command opcodes
  localparam logic [7:0] OP_NOP   = 8'h00;
  localparam logic [7:0] OP_READ  = 8'h10;
  localparam logic [7:0] OP_WRITE = 8'h08;
  localparam logic [7:0] OP_SET   = 8'h18;
  localparam logic [7:0] OP_CLEAR = 8'h20;

  // Frame geometry
  localparam logic [4:0] FRAME_BITS = 5'd24;
  localparam logic [4:0] CNT_SAT    = 5'd31;

  // Status bit positions and values
  localparam int          ST_FIXED_ONE  = 7;
  localparam int          ST_SCAN       = 6;
  localparam int          ST_AVG_DONE   = 3;
  localparam int          ST_CFG_ERR    = 2;
  localparam int          ST_BROWNOUT   = 0;
  localparam logic [7:0]  STATUS_RESET  = 8'h81;
  localparam logic [7:0]  STATUS_W1C    = 8'h09;

  // Writable bit masks; reserved positions stay zero
  localparam logic [7:0]  MASK_GLOBAL   = 8'h06;
  localparam logic [7:0]  MASK_OUTFMT   = 8'hB3;
  localparam logic [7:0]  MASK_AVGRATIO = 8'h07;
  localparam logic [7:0]  MASK_OSCTIME  = 8'h1F;
  localparam logic [7:0]  MASK_FULL     = 8'hFF;
  localparam int          GLB_SW_RESET  = 0;
  localparam logic [7:0]  CFG_RESET     = 8'h00;

  // Configuration registers handed to the rest of the converter
  typedef struct packed {
    logic [7:0] global_control;
    logic [7:0] output_format_control;
    logic [7:0] averaging_ratio_control;
    logic [7:0] oscillator_timing_control;
    logic [7:0] channel_function_select;
    logic [7:0] digital_direction_select;
    logic [7:0] output_drive_type_select;
    logic [7:0] digital_output_levels;
    logic [7:0] scan_control;
    logic [7:0] manual_channel_select;
    logic [7:0] scan_channel_enable;
  } arm_cfg_t;

  // Events reported by the converter core
  typedef struct packed {
    logic scan_running_flag;
    logic averaging_done;
    logic config_load_error;
    logic brownout;
  } arm_evt_t;

endpackage

//--- hw/arm_regmap.sv
// Register map, status flags and serial command port of the converter
`timescale 1ns/1ps
`default_nettype none

module arm_regmap
  import arm_pkg::*;
(
  // Clock and reset
  input  wire logic     MCLK_I,
  input  wire logic     RSTN_I,
  // Serial port, mode 0
  input  wire logic     CS_N_I,
  input  wire logic     SCLK_I,
  input  wire logic     SERIAL_IN_I,
  output var  logic     SERIAL_OUT_O,
  // Converter core side
  input  wire arm_evt_t EVT_I,
  input  wire logic [7:0] DIN_LEVELS_I,
  output var  arm_cfg_t CFG_O,
  output var  logic     SW_RESET_O
);

  logic       cs_q_reg;
  logic       sclk_q_reg;
  logic [23:0] shift_reg;
  logic [4:0] cnt_reg;
  logic [7:0] rd_data_reg;
  logic [7:0] rd_data_next;
  logic [6:0] out_sh_reg;
  logic       sdo_reg;
  arm_cfg_t   cfg_reg;
  arm_cfg_t   cfg_next;
  logic [7:0] din_reg;
  logic       scan_reg;
  logic       avg_reg;
  logic       avg_next;
  logic       cfgerr_reg;
  logic       cfgerr_next;
  logic       bor_reg;
  logic       bor_next;
  logic       swrst_reg;

  // Frame edge and command decode
  wire        cs_fall    = cs_q_reg & ~CS_N_I;
  wire        cs_rise    = ~cs_q_reg & CS_N_I;
  wire        sclk_rise  = ~CS_N_I & SCLK_I & ~sclk_q_reg;
  wire        sclk_fall  = ~CS_N_I & ~SCLK_I & sclk_q_reg;
  wire [7:0]  cmd_op     = shift_reg[23:16];
  wire [7:0]  cmd_addr   = shift_reg[15:8];
  wire [7:0]  cmd_data   = shift_reg[7:0];
  wire        frame_end  = cs_rise & (cnt_reg == FRAME_BITS);
  wire        op_write   = cmd_op == OP_WRITE;
  wire        op_set     = cmd_op == OP_SET;
  wire        op_clear   = cmd_op == OP_CLEAR;
  wire        cmd_mod    = frame_end & (op_write | op_set | op_clear);
  wire        cmd_read   = frame_end & (cmd_op == OP_READ);
  wire        glb_hit    = cmd_mod & (cmd_addr == ADDR_GLOBAL);
  wire        status_hit = cmd_mod & (cmd_addr == ADDR_STATUS);
  wire        sw_reset   = glb_hit & ~op_clear & cmd_data[GLB_SW_RESET];
  wire [7:0]  w1c        = (status_hit & ~op_clear) ? (cmd_data & STATUS_W1C) : 8'h00;

  wire [7:0]  status_val = {1'b1, scan_reg, 2'b00, avg_reg, cfgerr_reg, 1'b0, bor_reg};

  // Masked modify of one byte; unmasked bits keep their value
  function automatic logic [7:0] modify(input logic [7:0] cur, input logic [7:0] mask);
    logic [7:0] nv;
    nv = op_write ? cmd_data : (op_set ? (cur | cmd_data) : (cur & ~cmd_data));
    return (cur & ~mask) | (nv & mask);
  endfunction

  // Configuration next state
  always_comb begin
    cfg_next = cfg_reg;
    if (sw_reset) begin
      cfg_next = '0;
    end else if (cmd_mod) begin
      unique case (cmd_addr)
        ADDR_GLOBAL:   cfg_next.global_control =
                         modify(cfg_reg.global_control, MASK_GLOBAL);
        ADDR_OUTFMT:   cfg_next.output_format_control =
                         modify(cfg_reg.output_format_control, MASK_OUTFMT);
        ADDR_AVGRATIO: cfg_next.averaging_ratio_control =
                         modify(cfg_reg.averaging_ratio_control, MASK_AVGRATIO);
        ADDR_OSCTIME:  cfg_next.oscillator_timing_control =
                         modify(cfg_reg.oscillator_timing_control, MASK_OSCTIME);
        ADDR_CHFUNC:   cfg_next.channel_function_select =
                         modify(cfg_reg.channel_function_select, MASK_FULL);
        ADDR_DIGDIR:   cfg_next.digital_direction_select =
                         modify(cfg_reg.digital_direction_select, MASK_FULL);
        ADDR_DRVTYPE:  cfg_next.output_drive_type_select =
                         modify(cfg_reg.output_drive_type_select, MASK_FULL);
        ADDR_DOUTLVL:  cfg_next.digital_output_levels =
                         modify(cfg_reg.digital_output_levels, MASK_FULL);
        ADDR_SCANCTL:  cfg_next.scan_control =
                         modify(cfg_reg.scan_control, MASK_FULL);
        ADDR_MANCH:    cfg_next.manual_channel_select =
                         modify(cfg_reg.manual_channel_select, MASK_FULL);
        ADDR_SCANEN:   cfg_next.scan_channel_enable =
                         modify(cfg_reg.scan_channel_enable, MASK_FULL);
        default:       cfg_next = cfg_reg;
      endcase
    end
  end

  // Read data selection
  always_comb begin
    rd_data_next = rd_data_reg;
    if (cmd_read) begin
      // latch addressed value for next frame
      unique case (cmd_addr)
        ADDR_STATUS:   rd_data_next = status_val;
        ADDR_GLOBAL:   rd_data_next = cfg_reg.global_control;
        ADDR_OUTFMT:   rd_data_next = cfg_reg.output_format_control;
        ADDR_AVGRATIO: rd_data_next = cfg_reg.averaging_ratio_control;
        ADDR_OSCTIME:  rd_data_next = cfg_reg.oscillator_timing_control;
        ADDR_CHFUNC:   rd_data_next = cfg_reg.channel_function_select;
        ADDR_DIGDIR:   rd_data_next = cfg_reg.digital_direction_select;
        ADDR_DRVTYPE:  rd_data_next = cfg_reg.output_drive_type_select;
        ADDR_DOUTLVL:  rd_data_next = cfg_reg.digital_output_levels;
        ADDR_DINLVL:   rd_data_next = din_reg;
        ADDR_SCANCTL:  rd_data_next = cfg_reg.scan_control;
        ADDR_MANCH:    rd_data_next = cfg_reg.manual_channel_select;
        ADDR_SCANEN:   rd_data_next = cfg_reg.scan_channel_enable;
        default:       rd_data_next = 8'h00;
      endcase
    end else if (frame_end) begin
      rd_data_next = 8'h00;
    end
  end

  // Status flag next state; a new event wins over a clear
  always_comb begin
    avg_next    = EVT_I.averaging_done | (avg_reg & ~w1c[ST_AVG_DONE] & ~sw_reset);
    cfgerr_next = EVT_I.config_load_error | (cfgerr_reg & ~sw_reset);
    // clear by one, set by brown-out or reset
    bor_next    = EVT_I.brownout | sw_reset | (bor_reg & ~w1c[ST_BROWNOUT]);
  end

  // Serial shift and frame counter
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      cs_q_reg   <= 1'b1;
      sclk_q_reg <= 1'b0;
      shift_reg  <= '0;
      cnt_reg    <= '0;
    end else begin
      cs_q_reg   <= CS_N_I;
      sclk_q_reg <= SCLK_I;
      if (cs_fall) begin
        cnt_reg <= '0;
      end else if (sclk_rise) begin
        shift_reg <= {shift_reg[22:0], SERIAL_IN_I};
        cnt_reg   <= (cnt_reg == CNT_SAT) ? cnt_reg : cnt_reg + 5'd1;
      end
    end
  end

  // Serial output, MSB first, changes on falling clock
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      sdo_reg    <= 1'b0;
      out_sh_reg <= '0;
    end else if (cs_fall) begin
      sdo_reg    <= rd_data_reg[7];
      out_sh_reg <= rd_data_reg[6:0];
    end else if (sclk_fall) begin
      sdo_reg    <= out_sh_reg[6];
      out_sh_reg <= {out_sh_reg[5:0], 1'b0};
    end else if (CS_N_I) begin
      sdo_reg    <= 1'b0;
    end
  end

  // Register state
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      cfg_reg     <= '0;
      rd_data_reg <= 8'h00;
      din_reg     <= 8'h00;
      scan_reg    <= 1'b0;
      avg_reg     <= 1'b0;
      cfgerr_reg  <= 1'b0;
      bor_reg     <= 1'b1;
      swrst_reg   <= 1'b0;
    end else begin
      cfg_reg     <= cfg_next;
      rd_data_reg <= rd_data_next;
      din_reg     <= DIN_LEVELS_I;
      scan_reg    <= EVT_I.scan_running_flag;
      avg_reg     <= avg_next;
      cfgerr_reg  <= cfgerr_next;
      bor_reg     <= bor_next;
      swrst_reg   <= sw_reset;
    end
  end

  assign SERIAL_OUT_O = sdo_reg;
  assign CFG_O        = cfg_reg;
  assign SW_RESET_O   = swrst_reg;

  // Checks
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RSTN_I);

  a_status_fixed_bits: assert property (
      cmd_read && cmd_addr == ADDR_STATUS
      |=> rd_data_reg[7] && rd_data_reg[5:4] == 2'b00 && !rd_data_reg[1])
    else $error("status fixed bits wrong");
  a_status_reset_val: assert property (
      sw_reset && !EVT_I.scan_running_flag && !EVT_I.averaging_done
      && !EVT_I.config_load_error |=> status_val == STATUS_RESET)
    else $error("status not 0x81 after software reset");
  a_sw_reset_defaults: assert property (
      sw_reset |=> cfg_reg == '0 && bor_reg && SW_RESET_O
      && cfg_reg.global_control[GLB_SW_RESET] == 1'b0)
    else $error("software reset did not restore defaults");
  a_scan_follows: assert property (status_val[ST_SCAN] == $past(EVT_I.scan_running_flag))
    else $error("scan flag does not follow core");
  a_avg_set: assert property (EVT_I.averaging_done |=> status_val[ST_AVG_DONE])
    else $error("averaging flag not set");
  a_avg_clear: assert property (w1c[ST_AVG_DONE] && !EVT_I.averaging_done |=> !avg_reg)
    else $error("averaging flag not cleared");
  a_avg_hold: assert property (avg_reg && !w1c[ST_AVG_DONE] && !sw_reset |=> avg_reg)
    else $error("averaging flag lost");
  a_cfgerr_set: assert property (EVT_I.config_load_error |=> cfgerr_reg [*2])
    else $error("config error flag not held");
  a_cfgerr_sticky: assert property (cfgerr_reg && !sw_reset |=> cfgerr_reg)
    else $error("config error flag cleared by write");
  a_bor_clear: assert property (
      w1c[ST_BROWNOUT] && !EVT_I.brownout && !sw_reset |=> !bor_reg)
    else $error("brown-out flag not cleared");
  a_bor_set: assert property (EVT_I.brownout |=> bor_reg)
    else $error("brown-out flag not set");
  a_write_commit: assert property (
      cmd_mod && op_write && cmd_addr == ADDR_AVGRATIO
      |=> cfg_reg.averaging_ratio_control == ($past(cmd_data) & MASK_AVGRATIO))
    else $error("write not applied at frame end");
  a_read_return: assert property (
      cmd_read && cmd_addr == ADDR_STATUS |=> rd_data_reg == $past(status_val))
    else $error("read data not latched");
  a_read_shift_out: assert property (cs_fall |=> SERIAL_OUT_O == $past(rd_data_reg[7]))
    else $error("first output bit wrong");
  a_ro_write_ignored: assert property (
      cmd_mod && (cmd_addr == ADDR_DINLVL || cmd_addr == ADDR_STATUS)
      |=> cfg_reg == $past(cfg_reg))
    else $error("read-only write disturbed configuration");
  a_sdo_idle_low: assert property (CS_N_I |=> !SERIAL_OUT_O)
    else $error("serial output not low while deselected");
  a_reserved_zero: assert property (
      (cfg_reg.global_control & ~MASK_GLOBAL) == 8'h00
      && (cfg_reg.output_format_control & ~MASK_OUTFMT) == 8'h00
      && (cfg_reg.averaging_ratio_control & ~MASK_AVGRATIO) == 8'h00
      && (cfg_reg.oscillator_timing_control & ~MASK_OSCTIME) == 8'h00)
    else $error("reserved configuration bit set");
  a_write_full_byte: assert property (
      cmd_mod && op_write && cmd_addr == ADDR_SCANEN
      |=> cfg_reg.scan_channel_enable == $past(cmd_data))
    else $error("full byte write not applied");
  a_clear_bits: assert property (
      cmd_mod && op_clear && cmd_addr == ADDR_SCANEN
      |=> cfg_reg.scan_channel_enable
          == ($past(cfg_reg.scan_channel_enable) & ~$past(cmd_data)))
    else $error("clear-bit command not applied");
  a_set_bits: assert property (
      cmd_mod && op_set && cmd_addr == ADDR_SCANEN
      |=> cfg_reg.scan_channel_enable
          == ($past(cfg_reg.scan_channel_enable) | $past(cmd_data)))
    else $error("set-bit command not applied");
  a_cfgerr_no_write: assert property (
      status_hit && !EVT_I.config_load_error && !sw_reset |=> cfgerr_reg == $past(cfgerr_reg))
    else $error("config error flag changed by write");
  a_swrst_pulse: assert property (sw_reset |=> SW_RESET_O ##1 !SW_RESET_O)
    else $error("software reset pulse not one cycle");
  a_bor_stays_clear: assert property (
      !bor_reg && !EVT_I.brownout && !sw_reset |=> !bor_reg)
    else $error("brown-out flag set without cause");

  c_write_frame: cover property (cmd_mod && op_write);
  c_read_frame: cover property (cmd_read ##[1:20] cs_fall);
  c_sw_reset: cover property (sw_reset);
  c_avg_clear: cover property (avg_reg ##1 w1c[ST_AVG_DONE]);
  c_brownout_event: cover property (EVT_I.brownout ##1 bor_reg);

endmodule

`default_nettype wire

//--- verification/arm_host_model.sv
// Host controller model that sends mode 0 serial frames to the register map
`timescale 1ns/1ps
`default_nettype none

module arm_host_model
  import arm_pkg::*;
(
  // Clock
  input  wire logic clk_i,
  // Serial port
  input  wire logic serial_out_i,
  output var  logic cs_n_o,
  output var  logic sclk_o,
  output var  logic serial_in_o
);
  initial begin
    cs_n_o      = 1'b1;
    sclk_o      = 1'b0;
    serial_in_o = 1'b0;
  end

  task automatic frame(input logic [23:0] word, output logic [7:0] rdata);
    logic [23:0] cap;
    cap = 24'h00_0000;
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    repeat (3) @(posedge clk_i);
    for (int i = 23; i >= 0; i--) begin
      serial_in_o <= word[i];
      repeat (3) @(posedge clk_i);
      cap[i] = serial_out_i;
      sclk_o <= 1'b1;
      repeat (2) @(posedge clk_i);
      sclk_o <= 1'b0;
    end
    repeat (2) @(posedge clk_i);
    cs_n_o      <= 1'b1;
    serial_in_o <= ~word[0];
    repeat (3) @(posedge clk_i);
    rdata = cap[23:16];
  endtask
endmodule

`default_nettype wire

//--- verification/tb_adc_register_map_status.sv
// Self-checking bench for the register map and status flags
`timescale 1ns/1ps
`default_nettype none

module tb_adc_register_map_status
  import arm_pkg::*;
;
  logic       mclk;
  logic       rst_n;
  logic       cs_n;
  logic       sclk;
  logic       sin;
  logic       sout;
  arm_evt_t   evt;
  logic [7:0] din;
  arm_cfg_t   cfg;
  logic       sw_rst;
  int         miscompares;
  int         n_tests;
  int         n_swrst;
  logic [8:0] m;

  arm_regmap arm_regmap_i (
    .MCLK_I       (mclk),
    .RSTN_I       (rst_n),
    .CS_N_I       (cs_n),
    .SCLK_I       (sclk),
    .SERIAL_IN_I  (sin),
    .SERIAL_OUT_O (sout),
    .EVT_I        (evt),
    .DIN_LEVELS_I (din),
    .CFG_O        (cfg),
    .SW_RESET_O   (sw_rst)
  );

  arm_host_model arm_host_model_i (
    .clk_i        (mclk),
    .serial_out_i (sout),
    .cs_n_o       (cs_n),
    .sclk_o       (sclk),
    .serial_in_o  (sin)
  );

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (sw_rst === 1'b1) n_swrst++;
  end

  task automatic results();
    if (miscompares == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string what, input logic [87:0] exp, input logic [87:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] op, input logic [7:0] addr, input logic [7:0] data);
    logic [7:0] d;
    arm_host_model_i.frame({op, addr, data}, d);
  endtask

  task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    arm_host_model_i.frame({OP_READ, addr, 8'h00}, d);
    arm_host_model_i.frame({OP_NOP, 16'h0000}, d);
    chk($sformatf("addr_%h", addr), {80'h0, exp}, {80'h0, d});
  endtask

  task automatic ev(input arm_evt_t e);
    @(posedge mclk);
    evt <= e;
    @(posedge mclk);
    evt <= {e.scan_running_flag, 3'h0};
  endtask

  // Mapped flag and writable mask of each address
  function automatic logic [8:0] map(input logic [7:0] a);
    case (a)
      ADDR_GLOBAL:   return 9'h106;
      ADDR_OUTFMT:   return 9'h1B3;
      ADDR_AVGRATIO: return 9'h107;
      ADDR_OSCTIME:  return 9'h11F;
      ADDR_DINLVL:   return 9'h100;
      ADDR_CHFUNC, ADDR_DIGDIR, ADDR_DRVTYPE, ADDR_DOUTLVL,
      ADDR_SCANCTL, ADDR_MANCH, ADDR_SCANEN: return 9'h1FF;
      default:       return 9'h000;
    endcase
  endfunction

  initial begin
    rst_n = 1'b0;
    evt   = 4'h0;
    din   = 8'h5A;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    chk("cfg_reset", 88'h0, cfg);
    rd(ADDR_STATUS, 8'h81);
    for (int a = 1; a <= 18; a++) rd(8'(a), (8'(a) == ADDR_DINLVL) ? din : 8'h00);
    for (int a = 1; a <= 18; a++) begin
      m = map(8'(a));
      if (m[8]) wr(OP_WRITE, 8'(a), 8'hFE);
      rd(8'(a), (8'(a) == ADDR_DINLVL) ? din : (m[7:0] & 8'hFE));
    end
    chk("cfg_written", {8'h06, 8'hB2, 8'h06, 8'h1E, {7{8'hFE}}}, cfg);
    wr(OP_CLEAR, ADDR_SCANEN, 8'hF0);
    rd(ADDR_SCANEN, 8'h0E);
    wr(OP_SET, ADDR_SCANEN, 8'h81);
    rd(ADDR_SCANEN, 8'h8F);
    wr(OP_WRITE, ADDR_STATUS, 8'h76);
    rd(ADDR_STATUS, 8'h81);
    wr(OP_WRITE, ADDR_STATUS, 8'h01);
    rd(ADDR_STATUS, 8'h80);
    ev(4'h4);
    rd(ADDR_STATUS, 8'h88);
    wr(OP_WRITE, ADDR_STATUS, 8'h00);
    rd(ADDR_STATUS, 8'h88);
    wr(OP_SET, ADDR_STATUS, 8'h08);
    rd(ADDR_STATUS, 8'h80);
    ev(4'h2);
    rd(ADDR_STATUS, 8'h84);
    wr(OP_WRITE, ADDR_STATUS, 8'hFF);
    rd(ADDR_STATUS, 8'h84);
    ev(4'h8);
    rd(ADDR_STATUS, 8'hC4);
    ev(4'h1);
    rd(ADDR_STATUS, 8'h85);
    chk("swrst_idle", 88'h0, 88'(n_swrst));
    wr(OP_WRITE, ADDR_GLOBAL, 8'h01);
    chk("cfg_swrst", 88'h0, cfg);
    chk("swrst_pulse", 88'h1, 88'(n_swrst));
    rd(ADDR_STATUS, 8'h81);
    rd(ADDR_GLOBAL, 8'h00);
    wr(OP_WRITE, ADDR_SCANCTL, 8'h5C);
    wr(OP_WRITE, ADDR_STATUS, 8'h01);
    rd(ADDR_STATUS, 8'h80);
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    chk("cfg_rst_again", 88'h0, cfg);
    rd(ADDR_STATUS, 8'h81);
    results();
  end

  initial begin
    miscompares = 0;
    n_tests     = 0;
    n_swrst     = 0;
    repeat (40000) @(posedge mclk);
    miscompares++;
    results();
  end
endmodule

`default_nettype wire
